// file: rtl/frame_pkg.sv
// Constants of the line frame builder and parser.
// Assumes one bit clock enable per line bit derived outside.
package frame_pkg;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_BITS = 14;
  localparam int unsigned FIRST_OH_BITS = 2;
  localparam int unsigned GROUP_OH_BITS = 10;
  localparam int unsigned BLOCKS_PER_GROUP = 12;
  localparam int unsigned GROUPS = 4;
  localparam int unsigned AUX_RESERVED = 8;
  localparam int unsigned AUX_BITS = 48;
  localparam int unsigned BLOCK_BITS_TWO = 145;
  localparam int unsigned BLOCK_BITS_ONE = 289;
  localparam int unsigned FRAME_TWO_MIN = 7006;
  localparam int unsigned FRAME_TWO_NOM = 7008;
  localparam int unsigned FRAME_TWO_MAX = 7010;
  localparam int unsigned FRAME_ONE_MIN = 13918;
  localparam int unsigned FRAME_ONE_NOM = 13920;
  localparam int unsigned FRAME_ONE_MAX = 13922;
  localparam logic [13:0] SYNC_PATTERN = 14'h3f0d;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_TIME_US = 6000;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned FRAME_CYCLES = FRAME_TIME_US * CLK_MHZ;
  localparam int unsigned DEAD_BAND_UI = 2;
  // Stuffing counts of pairs
  localparam logic [1:0] STUFF_NOMINAL = 2'h1;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage : frame_pkg

// file: rtl/byte_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo
`default_nettype wire

// file: rtl/sync_hunter.sv
// Receive sync word detector and frame length measure.
// Assumes descrambled bits arrive with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module sync_hunter
  import frame_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rx_bit,
  input wire logic rx_strobe,
  input wire logic one_pair,
  output logic rx_frame_start,
  output logic [1:0] rx_stuff_pairs,
  output logic rx_length_error
);
  logic [13:0] shift;
  logic [15:0] len;
  logic [15:0] min_len;
  logic seen;
  logic hit;
  assign min_len = one_pair ? 16'(FRAME_ONE_MIN) : 16'(FRAME_TWO_MIN);
  assign hit = rx_strobe && ({shift[12:0], rx_bit} == SYNC_PATTERN);
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      shift <= '0;
      len <= CNT_RESET;
      seen <= 1'b0;
      rx_frame_start <= 1'b0;
      rx_stuff_pairs <= STUFF_NOMINAL;
      rx_length_error <= 1'b0;
    end
    else
    begin
      rx_frame_start <= 1'b0;
      rx_length_error <= 1'b0;
      if (rx_strobe)
      begin
        shift <= {shift[12:0], rx_bit};
        len <= len + 16'h0001;
      end
      // Length is known only when the next sync word lands
      if (hit)
      begin
        // Hit bit opens the next span, so spacing equals frame length
        len <= 16'h0001;
        seen <= 1'b1;
        rx_frame_start <= seen;
        if (seen && len == min_len)
          rx_stuff_pairs <= 2'h0;
        else if (seen && len == min_len + 16'h0002)
          rx_stuff_pairs <= 2'h1;
        else if (seen && len == min_len + 16'h0004)
          rx_stuff_pairs <= 2'h2;
        else
          rx_length_error <= seen;
      end
    end
  end
endmodule : sync_hunter
`default_nettype wire

// file: rtl/frame_builder.sv
// Transmit frame builder with receive frame length measure.
// Assumes a bit strobe from the line side and a byte source.
`timescale 1ns/1ps
`default_nettype none
module frame_builder
  import frame_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic one_pair,
  input wire logic link_ready,
  input wire logic bit_strobe,
  input wire logic [7:0] core_data,
  input wire logic core_valid,
  output logic core_ready,
  input wire logic [39:0] aux_data,
  input wire logic [39:0] aux_used,
  input wire logic [31:0] overhead_data,
  input wire logic signed [7:0] phase_error,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic tx_frame_start,
  output logic [1:0] tx_stuff_pairs,
  output logic tx_fifo_underrun,
  input wire logic rx_bit,
  input wire logic rx_strobe,
  output logic rx_frame_start,
  output logic [1:0] rx_stuff_pairs,
  output logic rx_length_error
);
  // ---------------------------------------------------------------
  // Section kinds
  // ---------------------------------------------------------------
  typedef enum {
    SEC_IDLE,
    SEC_SYNC,
    SEC_OH,
    SEC_AUX,
    SEC_PAYLOAD,
    SEC_STUFF
  } section_t;
  section_t sec;
  logic [8:0] sec_cnt;
  logic [1:0] group;
  logic [3:0] block;
  logic [5:0] aux_idx;
  logic [5:0] oh_idx;
  logic [2:0] stuff_left;
  logic [1:0] stuff_now;
  logic [7:0] shreg;
  logic [2:0] bit_idx;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [8:0] block_bytes_bits;
  logic next_tx_bit;
  logic aux_value;
  logic signed [7:0] band;
  assign block_bytes_bits = one_pair ? 9'(BLOCK_BITS_ONE - 1)
                                     : 9'(BLOCK_BITS_TWO - 1);
  assign band = 8'sd1 + 8'(DEAD_BAND_UI / 2);
  // ---------------------------------------------------------------
  // Payload buffer
  // ---------------------------------------------------------------
  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_data(core_data),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // Byte leaves the buffer when its first bit is due
  assign fifo_pop = bit_strobe && sec == SEC_PAYLOAD && bit_idx == 3'h0;
  // ---------------------------------------------------------------
  // Bit selection
  // ---------------------------------------------------------------
  always_comb
  begin
    aux_value = 1'b1;
    if (aux_idx >= 6'(AUX_RESERVED))
      aux_value = aux_used[aux_idx - 6'(AUX_RESERVED)]
                  ? aux_data[aux_idx - 6'(AUX_RESERVED)] : 1'b1;
    else
      aux_value = 1'b1;
    next_tx_bit = 1'b1;
    unique case (sec)
      SEC_IDLE: next_tx_bit = 1'b1;
      SEC_SYNC: next_tx_bit = SYNC_PATTERN[4'(SYNC_BITS - 1) - sec_cnt[3:0]];
      SEC_OH: next_tx_bit = overhead_data[oh_idx[4:0]];
      SEC_AUX: next_tx_bit = aux_value;
      SEC_PAYLOAD: next_tx_bit = (bit_idx == 3'h0)
                                 ? (fifo_valid ? fifo_data[0] : 1'b1)
                                 : shreg[bit_idx];
      SEC_STUFF: next_tx_bit = 1'b1;
    endcase
  end
  // ---------------------------------------------------------------
  // Stuffing decision with dead band
  // ---------------------------------------------------------------
  always_comb
  begin
    stuff_now = STUFF_NOMINAL;
    if (phase_error > band)
      stuff_now = 2'h2;
    else if (phase_error < -band)
      stuff_now = 2'h0;
  end
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sec <= SEC_IDLE;
      sec_cnt <= '0;
      group <= '0;
      block <= '0;
      aux_idx <= '0;
      oh_idx <= '0;
      stuff_left <= '0;
      tx_stuff_pairs <= STUFF_NOMINAL;
      tx_frame_start <= 1'b0;
      tx_bit <= 1'b1;
      tx_bit_valid <= 1'b0;
      bit_idx <= '0;
      shreg <= 8'hff;
      tx_fifo_underrun <= 1'b0;
    end
    else
    begin
      tx_frame_start <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_fifo_underrun <= 1'b0;
      if (bit_strobe)
      begin
        tx_bit <= next_tx_bit;
        tx_bit_valid <= 1'b1;
        sec_cnt <= sec_cnt + 9'h001;
        unique case (sec)
          SEC_IDLE:
          begin
            if (link_ready)
            begin
              // Shared strobe gives aligned starts on all pairs
              sec <= SEC_SYNC;
              sec_cnt <= '0;
              aux_idx <= '0;
              oh_idx <= '0;
              group <= '0;
            end
          end
          SEC_SYNC:
          begin
            // Start marks the first sync bit, not the bit before it
            if (sec_cnt == 9'h000)
            begin
              tx_frame_start <= 1'b1;
              tx_stuff_pairs <= stuff_now;
            end
            if (sec_cnt == 9'(SYNC_BITS - 1))
            begin
              sec <= SEC_OH;
              sec_cnt <= '0;
            end
          end
          SEC_OH:
          begin
            oh_idx <= oh_idx + 6'h01;
            if (sec_cnt == ((group == 2'h0) ? 9'(FIRST_OH_BITS - 1)
                                            : 9'(GROUP_OH_BITS - 1)))
            begin
              sec <= SEC_AUX;
              sec_cnt <= '0;
              block <= '0;
            end
          end
          SEC_AUX:
          begin
            aux_idx <= aux_idx + 6'h01;
            sec <= SEC_PAYLOAD;
            sec_cnt <= '0;
            bit_idx <= '0;
          end
          SEC_PAYLOAD:
          begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h0)
            begin
              shreg <= fifo_valid ? fifo_data : 8'hff;
              tx_fifo_underrun <= !fifo_valid;
            end
            if (sec_cnt == block_bytes_bits - 9'h001)
            begin
              sec_cnt <= '0;
              if (block != 4'(BLOCKS_PER_GROUP - 1))
              begin
                block <= block + 4'h1;
                sec <= SEC_AUX;
              end
              else if (group != 2'(GROUPS - 1))
              begin
                group <= group + 2'h1;
                sec <= SEC_OH;
              end
              else if (tx_stuff_pairs != 2'h0)
              begin
                sec <= SEC_STUFF;
                stuff_left <= {tx_stuff_pairs, 1'b0} - 3'h1;
              end
              else
              begin
                sec <= SEC_SYNC;
                aux_idx <= '0;
                oh_idx <= '0;
                group <= '0;
                if (!link_ready)
                  sec <= SEC_IDLE;
              end
            end
          end
          SEC_STUFF:
          begin
            stuff_left <= stuff_left - 3'h1;
            if (stuff_left == 3'h0)
            begin
              // Frame end: lengths land on 3 options
              sec <= link_ready ? SEC_SYNC : SEC_IDLE;
              sec_cnt <= '0;
              aux_idx <= '0;
              oh_idx <= '0;
              group <= '0;
            end
          end
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Receive length measure
  // ---------------------------------------------------------------
  sync_hunter u_hunter (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rx_bit(rx_bit),
    .rx_strobe(rx_strobe),
    .one_pair(one_pair),
    .rx_frame_start(rx_frame_start),
    .rx_stuff_pairs(rx_stuff_pairs),
    .rx_length_error(rx_length_error)
  );
  // Bit strobe comes from the shared exchange clock
endmodule : frame_builder
`default_nettype wire

// file: verif/frame_builder_properties.sv
// Port checker for the frame builder.
// Assumes a bind from the bench onto frame_builder.
`timescale 1ns/1ps
`default_nettype none
module frame_builder_properties
  import frame_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic one_pair,
  input wire logic link_ready,
  input wire logic bit_strobe,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_frame_start,
  input wire logic [1:0] tx_stuff_pairs,
  input wire logic rx_strobe,
  input wire logic rx_frame_start,
  input wire logic [1:0] rx_stuff_pairs,
  input wire logic rx_length_error
);
  // ------
  // Bits since last start
  // ------
  int unsigned vcnt;
  logic seen;
  // Cleared on mode or link change, a cut frame has no legal length
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link_ready || $changed(one_pair))
    begin
      vcnt <= 0;
      seen <= 1'b0;
    end
    else if (tx_frame_start)
    begin
      vcnt <= 1;
      seen <= 1'b1;
    end
    else if (tx_bit_valid)
      vcnt <= vcnt + 1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  AST_VALID_AFTER_STROBE: assert property (bit_strobe |=> tx_bit_valid)
    else $error("valid missing");
  AST_VALID_CAUSE: assert property (tx_bit_valid |-> $past(bit_strobe))
    else $error("valid without strobe");
  AST_BIT_STANDS: assert property (!tx_bit_valid |-> $stable(tx_bit))
    else $error("bit moved");
  AST_START_SYNC: assert property (tx_frame_start |->
    tx_bit_valid && tx_bit == SYNC_PATTERN[13]) else $error("bad start");
  AST_START_LINK: assert property (tx_frame_start |-> $past(link_ready))
    else $error("start while link down");
  AST_START_GAP: assert property (tx_frame_start |=> !tx_frame_start [*8])
    else $error("starts too close");
  AST_STUFF_LEGAL: assert property (tx_stuff_pairs != 2'h3 &&
    rx_stuff_pairs != 2'h3) else $error("three stuffing pairs");
  AST_STUFF_AT_START: assert property ($changed(tx_stuff_pairs) |->
    tx_frame_start) else $error("stuffing changed in frame");
  AST_FRAME_LEN: assert property (tx_frame_start && seen |-> (one_pair ?
    vcnt inside {FRAME_ONE_MIN, FRAME_ONE_NOM, FRAME_ONE_MAX} :
    vcnt inside {FRAME_TWO_MIN, FRAME_TWO_NOM, FRAME_TWO_MAX}))
    else $error("illegal frame length");
  AST_RX_HIT: assert property ((rx_frame_start || rx_length_error) |->
    $past(rx_strobe)) else $error("rx event without bit");
  cover property (tx_frame_start && tx_stuff_pairs == 2'h2);
  cover property (tx_frame_start && tx_stuff_pairs == 2'h0);
  cover property (rx_length_error);
endmodule : frame_builder_properties
`default_nettype wire

// file: verif/far_end_peer.sv
// Far end transceiver sending framed bits.
// Assumes the bench calls send_frame one at a time.
`timescale 1ns/1ps
`default_nettype none
module far_end_peer
  import frame_pkg::*;
(
  input wire logic ref_clk,
  output logic rx_bit,
  output logic rx_strobe
);
  initial
  begin
    rx_bit = 1'b0;
    rx_strobe = 1'b0;
  end
  // Sync msb first then ones; len carries the stuffing
  task automatic send_frame(input int len);
    for (int i = 0; i < len; i++)
    begin
      @(posedge ref_clk);
      #1;
      rx_strobe = 1'b1;
      rx_bit = (i < 14) ? SYNC_PATTERN[13 - i] : 1'b1;
    end
    @(posedge ref_clk);
    #1;
    rx_strobe = 1'b0;
    // Released line, never the held value
    rx_bit = ~rx_bit;
  endtask : send_frame
endmodule : far_end_peer
`default_nettype wire

// file: verif/cap_hdsl_frame_builder_tb.sv
// Self-checking bench of the frame builder.
// Assumes frame_pkg and the design files compiled first.
`timescale 1ns/1ps
`default_nettype none
module cap_hdsl_frame_builder_tb
  import frame_pkg::*;
;
  logic ref_clk, sys_rst, one_pair, link_ready, bit_strobe;
  logic [7:0] core_data;
  logic core_valid, core_ready, tx_bit, tx_bit_valid, tx_frame_start;
  logic [39:0] aux_data, aux_used;
  logic [31:0] overhead_data;
  logic signed [7:0] phase_error;
  logic [1:0] tx_stuff_pairs, rx_stuff_pairs;
  logic tx_fifo_underrun, rx_bit, rx_strobe, rx_frame_start, rx_length_error;
  int n_errors, tests_run, n_starts, last_len, pos, n_rx_err, n_under;
  logic grab, grabbing;
  logic fb [0:1799];
  logic [1:0] rq [$];
  frame_builder frame_builder_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .one_pair(one_pair), .link_ready(link_ready), .bit_strobe(bit_strobe),
    .core_data(core_data), .core_valid(core_valid), .core_ready(core_ready),
    .aux_data(aux_data), .aux_used(aux_used), .overhead_data(overhead_data),
    .phase_error(phase_error), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_frame_start(tx_frame_start), .tx_stuff_pairs(tx_stuff_pairs),
    .tx_fifo_underrun(tx_fifo_underrun), .rx_bit(rx_bit),
    .rx_strobe(rx_strobe), .rx_frame_start(rx_frame_start),
    .rx_stuff_pairs(rx_stuff_pairs), .rx_length_error(rx_length_error));
  far_end_peer far_end_peer_inst (.ref_clk(ref_clk), .rx_bit(rx_bit),
    .rx_strobe(rx_strobe));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ------
  // Monitor
  // ------
  always @(posedge ref_clk)
  begin
    if (tx_bit_valid === 1'b1)
    begin
      if (tx_frame_start === 1'b1)
      begin
        last_len = pos;
        n_starts++;
        grabbing = grab;
        grab = 1'b0;
        pos = 0;
      end
      if (grabbing && pos < 1800)
        fb[pos] = tx_bit;
      pos++;
    end
    if (rx_frame_start === 1'b1)
      rq.push_back(rx_stuff_pairs);
    if (rx_length_error === 1'b1)
      n_rx_err++;
    if (tx_fifo_underrun === 1'b1)
      n_under++;
  end
  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic wait_start();
    int k;
    k = n_starts;
    for (int i = 0; i < 15000 && n_starts == k; i++)
      @(posedge ref_clk);
    #1;
  endtask : wait_start
  task automatic fill_fifo();
    int n;
    n = 0;
    repeat (20)
    begin
      @(posedge ref_clk);
      if (core_ready === 1'b1)
        n++;
    end
    #1;
    check("fifo accepted", n, FIFO_DEPTH);
  endtask : fill_fifo
  task automatic two_pair();
    logic [13:0] sw;
    logic [7:0] b;
    int prev;
    int pe [4] = '{5, -5, 2, -3};
    int ex [4] = '{2, 0, 1, 0};
    grab = 1'b1;
    link_ready = 1'b1;
    bit_strobe = 1'b1;
    wait_start();
    wait_start();
    check("two pair length", last_len, FRAME_TWO_NOM);
    for (int i = 0; i < 14; i++)
      sw[13 - i] = fb[i];
    for (int i = 0; i < 8; i++)
      b[i] = fb[17 + i];
    check("sync word", sw, SYNC_PATTERN);
    check("first overhead", {fb[15], fb[14]}, 2'h2);
    check("first byte", b, 8'h5a);
    for (int k = 0; k < 8; k++)
      check("reserved aux", fb[16 + k * 145], 1'h1);
    check("aux 9 and 10", {fb[1321], fb[1176]}, 2'h2);
    check("group two", {fb[1766], fb[1765], fb[1756]}, 3'h6);
    prev = 1;
    for (int i = 0; i < 4; i++)
    begin
      phase_error = 8'(pe[i]);
      wait_start();
      check("stuff pairs", tx_stuff_pairs, ex[i]);
      check("frame length", last_len, FRAME_TWO_MIN + 2 * prev);
      prev = ex[i];
    end
    wait_start();
    check("frame length", last_len, FRAME_TWO_MIN + 2 * prev);
  endtask : two_pair
  task automatic rx_frames();
    int lens [6] = '{7008, 7010, 7006, 6998, 7008, 14};
    foreach (lens[i])
      far_end_peer_inst.send_frame(lens[i]);
    repeat (4) @(posedge ref_clk);
    #1;
    check("rx stuff pairs", {rq[0], rq[1], rq[2]}, 6'h18);
    check("rx length errors", n_rx_err, 1);
  endtask : rx_frames
  task automatic one_pair_frame();
    logic [7:0] b;
    link_ready = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    one_pair = 1'b1;
    phase_error = 8'sh00;
    grab = 1'b1;
    link_ready = 1'b1;
    wait_start();
    wait_start();
    for (int i = 0; i < 8; i++)
      b[i] = fb[306 + i];
    check("one pair length", last_len, FRAME_ONE_NOM);
    check("one pair block", {b, fb[305], fb[16]}, 10'h16b);
    // Starve the buffer while the line keeps pulling bytes
    core_valid = 1'b0;
    repeat (100) @(posedge ref_clk);
    #1;
    check("underrun flagged", n_under > 0, 1'h1);
    core_valid = 1'b1;
  endtask : one_pair_frame
  initial
  begin
    sys_rst = 1'b1;
    one_pair = 1'b0;
    link_ready = 1'b0;
    bit_strobe = 1'b0;
    core_data = 8'h5a;
    core_valid = 1'b1;
    aux_data = 40'h0;
    aux_used = 40'h1;
    overhead_data = 32'h0000_0802;
    phase_error = 8'sh00;
    grab = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    check("reset outputs", {tx_bit, tx_bit_valid, tx_frame_start,
      tx_stuff_pairs}, 5'h11);
    fill_fifo();
    fork
      two_pair();
      rx_frames();
    join
    one_pair_frame();
    print_verdict();
  end
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule : cap_hdsl_frame_builder_tb
bind frame_builder frame_builder_properties frame_builder_properties_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .one_pair(one_pair),
  .link_ready(link_ready), .bit_strobe(bit_strobe), .tx_bit(tx_bit),
  .tx_bit_valid(tx_bit_valid), .tx_frame_start(tx_frame_start),
  .tx_stuff_pairs(tx_stuff_pairs), .rx_strobe(rx_strobe),
  .rx_frame_start(rx_frame_start), .rx_stuff_pairs(rx_stuff_pairs),
  .rx_length_error(rx_length_error));
`default_nettype wire
